// ===== hdl/wgs_status_bank.sv
`timescale 1ns/1ps
// Behaviour
// - supply undervoltage comparator enabled only while transceiver mode bit is 1
// - wake leaving fail-safe also sets the matching source flag
// - wake register b bit 4 set on gp pin wake when configured wake
// - level bit 7 shows development mode from test pin
// - level bit 6 shows external pull-up detected on interrupt pin
// - level bit 4 gp pin level, bit 0 hv pin level
// - level register refreshed in normal, stop, init and restart
// - cyclic sense: gp and hv level bits updated once per sampling instant; bits 7 and 6 every clock
// - gp level not reported when gp pin is fail output
// - disabled pin function freezes its level bit
// - hv measure enable clears and freezes both level bits
// - overcurrent bit 6 set on gp pin overcurrent in switch modes
// - one overcurrent flag; stays set after reconfiguration until cleared
// - open-load bit 6 set only in high-side switch mode
// - reserved bits always read zero
// - reset clears wake register b; restart keeps bit 6 only
// - flags stay latched until the host clears them, a soft reset clears them, or (wake register b only) a restart
module wgs_status_bank (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SOFT_RESET,
	input wire logic RESTART,
	input wire wgs_pkg::wgs_mode_t MODE,
	input wire logic CYCLIC_SENSE,
	input wire logic SAMPLE_STROBE,
	input wire logic TRX_MODE_BIT,
	input wire wgs_pkg::wgs_gp_mode_t GP_MODE,
	input wire logic HV_FUNC_EN,
	input wire logic HV_MEASURE_EN,
	input wire wgs_pkg::wgs_events_t EVENTS,
	input wire logic FAILSAFE_EXIT,
	input wire logic TEST_PIN,
	input wire logic IRQ_PULLUP,
	input wire logic GP_PIN,
	input wire logic HV_PIN,
	input wire wgs_pkg::wgs_cmd_t CMD,
	output logic [7:0] RDATA,
	output logic RVALID,
	output logic SUPPLY_UV_CMP_EN
);
	import wgs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage read only by second
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
		end else begin
			pin_s1_q <= {TEST_PIN, IRQ_PULLUP, GP_PIN, HV_PIN};
			pin_s2_q <= pin_s1_q;
		end
	end
	wire test_s = pin_s2_q[3];
	wire pullup_s = pin_s2_q[2];
	wire gp_s = pin_s2_q[1];
	wire hv_s = pin_s2_q[0];

	////////////////////////////////////////////////////////////////////////
	// clear decode
	wire clr_a = CMD.clr && (CMD.addr == ADDR_WAKE_A);
	wire clr_b = CMD.clr && (CMD.addr == ADDR_WAKE_B);
	wire clr_oc = CMD.clr && (CMD.addr == ADDR_OC);
	wire clr_ol = CMD.clr && (CMD.addr == ADDR_OL);
	wire soft_rst = SOFT_RESET;

	////////////////////////////////////////////////////////////////////////
	// wake flags; set wins over clear
	logic bus_wake_flag_q;
	logic timer_wake_flag_q;
	logic hv_pin_wake_flag_q;
	logic gp_pin_wake_flag_q;
	wire set_bus = EVENTS.bus_wake || (FAILSAFE_EXIT && EVENTS.bus_wake);
	wire set_tmr = EVENTS.timer_wake;
	wire set_hv = EVENTS.hv_wake;
	wire set_gp = EVENTS.gp_wake && (GP_MODE == GP_WAKE);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bus_wake_flag_q <= 1'b0;
			timer_wake_flag_q <= 1'b0;
			hv_pin_wake_flag_q <= 1'b0;
		end else if (soft_rst) begin
			bus_wake_flag_q <= 1'b0;
			timer_wake_flag_q <= 1'b0;
			hv_pin_wake_flag_q <= 1'b0;
		end else begin
			bus_wake_flag_q <= set_bus || (bus_wake_flag_q && !(clr_a && CMD.clr_mask[BIT_BUS_WAKE]));
			timer_wake_flag_q <= set_tmr ||
				(timer_wake_flag_q && !(clr_a && CMD.clr_mask[BIT_TIMER_WAKE]));
			hv_pin_wake_flag_q <= set_hv ||
				(hv_pin_wake_flag_q && !(clr_a && CMD.clr_mask[BIT_HV_WAKE]));
		end
	end
	// restart clears b (bit 6 kept, reserved here)
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			gp_pin_wake_flag_q <= 1'b0;
		end else if (soft_rst || RESTART) begin
			gp_pin_wake_flag_q <= 1'b0;
		end else begin
			gp_pin_wake_flag_q <= set_gp ||
				(gp_pin_wake_flag_q && !(clr_b && CMD.clr_mask[BIT_GP_WAKE]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fault flags
	logic gp_overcurrent_flag_q;
	logic gp_open_load_flag_q;
	wire sw_mode = (GP_MODE == GP_LOW_SW) || (GP_MODE == GP_HIGH_SW);
	wire set_oc = EVENTS.overcurrent && sw_mode;
	wire set_ol = EVENTS.open_load && (GP_MODE == GP_HIGH_SW);
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			gp_overcurrent_flag_q <= 1'b0;
			gp_open_load_flag_q <= 1'b0;
		end else if (soft_rst) begin
			gp_overcurrent_flag_q <= 1'b0;
			gp_open_load_flag_q <= 1'b0;
		end else begin
			gp_overcurrent_flag_q <= set_oc ||
				(gp_overcurrent_flag_q && !(clr_oc && CMD.clr_mask[BIT_OC]));
			gp_open_load_flag_q <= set_ol ||
				(gp_open_load_flag_q && !(clr_ol && CMD.clr_mask[BIT_OL]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level status
	logic dev_lvl_q;
	logic pullup_q;
	logic gp_pin_level_q;
	logic hv_pin_level_q;
	wire live_mode = (MODE == M_NORMAL) || (MODE == M_STOP) || (MODE == M_INIT) ||
		(MODE == M_RESTART);
	// cyclic sense updates only on sample
	wire lvl_tick = CYCLIC_SENSE ? SAMPLE_STROBE : live_mode;
	// gp level gated by its function
	wire gp_upd = lvl_tick && (GP_MODE != GP_OFF) && (GP_MODE != GP_FAIL_OUT);
	// hv level gated by its function
	wire hv_upd = lvl_tick && HV_FUNC_EN;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dev_lvl_q <= 1'b0;
			pullup_q <= 1'b0;
			gp_pin_level_q <= 1'b0;
			hv_pin_level_q <= 1'b0;
		end else begin
			dev_lvl_q <= test_s;
			pullup_q <= pullup_s;
			if (HV_MEASURE_EN) begin
				gp_pin_level_q <= 1'b0;
				hv_pin_level_q <= 1'b0;
			end else begin
				if (gp_upd)
					gp_pin_level_q <= gp_s;
				if (hv_upd)
					hv_pin_level_q <= hv_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path; reads have no side effect
	logic [7:0] wake_a_v;
	logic [7:0] wake_b_v;
	logic [7:0] level_v;
	logic [7:0] oc_v;
	logic [7:0] ol_v;
	logic [7:0] rd_mux;
	always_comb begin
		wake_a_v = RESET_VAL;
		wake_a_v[BIT_BUS_WAKE] = bus_wake_flag_q;
		wake_a_v[BIT_TIMER_WAKE] = timer_wake_flag_q;
		wake_a_v[BIT_HV_WAKE] = hv_pin_wake_flag_q;
		wake_b_v = RESET_VAL;
		wake_b_v[BIT_GP_WAKE] = gp_pin_wake_flag_q;
		level_v = RESET_VAL;
		level_v[BIT_DEV_LVL] = dev_lvl_q;
		level_v[BIT_PULLUP] = pullup_q;
		level_v[BIT_GP_LVL] = gp_pin_level_q;
		level_v[BIT_HV_LVL] = hv_pin_level_q;
		oc_v = RESET_VAL;
		oc_v[BIT_OC] = gp_overcurrent_flag_q;
		ol_v = RESET_VAL;
		ol_v[BIT_OL] = gp_open_load_flag_q;
		case (CMD.addr)
			ADDR_WAKE_A: rd_mux = wake_a_v;
			ADDR_WAKE_B: rd_mux = wake_b_v;
			ADDR_LEVEL: rd_mux = level_v;
			ADDR_OC: rd_mux = oc_v;
			ADDR_OL: rd_mux = ol_v;
			default: rd_mux = RESET_VAL;
		endcase
	end
	// read returns value before any same-cycle clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= RESET_VAL;
			RVALID <= 1'b0;
		end else begin
			RVALID <= CMD.rd;
			if (CMD.rd)
				RDATA <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// comparator enable
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			SUPPLY_UV_CMP_EN <= 1'b0;
		else
			SUPPLY_UV_CMP_EN <= (TRX_MODE_BIT == TRX_ACTIVE);
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// comparator follows mode bit
	a_uv_cmp_en: assert property (@(posedge CLK) disable iff (!RST_N)
		1'b1 |=> SUPPLY_UV_CMP_EN == $past(TRX_MODE_BIT))
		else $error("comparator enable wrong");
	a_bus_wake_set: assert property (@(posedge CLK) disable iff (!RST_N)
		EVENTS.bus_wake && !soft_rst |=> bus_wake_flag_q)
		else $error("bus wake flag not set");
	// gp wake sets only in wake mode
	a_gp_wake_mode: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(gp_pin_wake_flag_q) |-> $past(GP_MODE) == GP_WAKE)
		else $error("gp wake outside wake mode");
	a_meas_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		HV_MEASURE_EN ##1 HV_MEASURE_EN |-> !gp_pin_level_q && !hv_pin_level_q)
		else $error("levels not cleared in measure");
	a_oc_mode: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(gp_overcurrent_flag_q) |-> $past(sw_mode))
		else $error("overcurrent set outside switch mode");
	a_ol_mode: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(gp_open_load_flag_q) |-> $past(GP_MODE) == GP_HIGH_SW)
		else $error("open load outside high-side");
	a_oc_latched: assert property (@(posedge CLK) disable iff (!RST_N)
		gp_overcurrent_flag_q && !clr_oc && !soft_rst |=> gp_overcurrent_flag_q)
		else $error("overcurrent flag self-cleared");
	a_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_N)
		CMD.rd && CMD.addr == ADDR_OC |=> RDATA[7] == 1'b0 && RDATA[5:0] == 6'h00)
		else $error("reserved bits nonzero");
	a_fo_freeze: assert property (@(posedge CLK) disable iff (!RST_N)
		GP_MODE == GP_FAIL_OUT && !HV_MEASURE_EN |=> $stable(gp_pin_level_q))
		else $error("gp level moved in fail output mode");
	a_restart_b: assert property (@(posedge CLK) disable iff (!RST_N)
		RESTART |=> !gp_pin_wake_flag_q)
		else $error("restart left wake b set");
	a_failsafe_src: assert property (@(posedge CLK) disable iff (!RST_N)
		FAILSAFE_EXIT && EVENTS.hv_wake && !soft_rst |=> hv_pin_wake_flag_q)
		else $error("fail-safe exit source not flagged");
	a_strap_levels: assert property (@(posedge CLK) disable iff (!RST_N)
		1'b1 |=> dev_lvl_q == $past(test_s) && pullup_q == $past(pullup_s))
		else $error("strap level wrong");
	a_cyclic_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		CYCLIC_SENSE && !SAMPLE_STROBE && !HV_MEASURE_EN |=>
		$stable(hv_pin_level_q) && $stable(gp_pin_level_q))
		else $error("level moved between samples");
	// hv function off freezes its level
	a_hv_func_off: assert property (@(posedge CLK) disable iff (!RST_N)
		!HV_FUNC_EN && !HV_MEASURE_EN |=> $stable(hv_pin_level_q))
		else $error("hv level moved with function off");
	a_oc_survives: assert property (@(posedge CLK) disable iff (!RST_N)
		gp_overcurrent_flag_q && !sw_mode && !clr_oc && !soft_rst |=> gp_overcurrent_flag_q)
		else $error("overcurrent lost on reconfiguration");
	// soft reset clears every wake flag
	a_softrst_clear: assert property (@(posedge CLK) disable iff (!RST_N)
		SOFT_RESET |=> !gp_pin_wake_flag_q && !bus_wake_flag_q && !timer_wake_flag_q &&
		!hv_pin_wake_flag_q)
		else $error("soft reset left wake flag set");
	a_read_valid: assert property (@(posedge CLK) disable iff (!RST_N)
		CMD.rd |=> RVALID)
		else $error("read not answered");
endmodule : wgs_status_bank

// ===== hdl/wgs_pkg.sv
package wgs_pkg;
	// register addresses (7-bit serial address space)
	localparam logic [6:0] ADDR_WAKE_A = 7'h46;
	localparam logic [6:0] ADDR_WAKE_B = 7'h47;
	localparam logic [6:0] ADDR_LEVEL = 7'h48;
	localparam logic [6:0] ADDR_OC = 7'h54;
	localparam logic [6:0] ADDR_OL = 7'h55;
	// field positions
	localparam int BIT_BUS_WAKE = 5;
	localparam int BIT_TIMER_WAKE = 4;
	localparam int BIT_HV_WAKE = 0;
	localparam int BIT_GP_WAKE = 4;
	localparam int BIT_KEEP_B = 6;
	localparam int BIT_DEV_LVL = 7;
	localparam int BIT_PULLUP = 6;
	localparam int BIT_GP_LVL = 4;
	localparam int BIT_HV_LVL = 0;
	localparam int BIT_OC = 6;
	localparam int BIT_OL = 6;
	localparam logic [7:0] RESET_VAL = 8'h00;
	// transceiver mode field value that powers the supply comparator
	localparam logic TRX_ACTIVE = 1'b1;
	// restart keeps only bit 6 of wake register b
	localparam logic [7:0] KEEP_MASK_B = 8'h40;
	typedef enum logic [2:0] {GP_OFF, GP_WAKE, GP_LOW_SW, GP_HIGH_SW, GP_FAIL_OUT} wgs_gp_mode_t;
	typedef enum logic [2:0] {M_NORMAL, M_STOP, M_INIT, M_RESTART, M_SLEEP, M_FAILSAFE} wgs_mode_t;
	typedef struct packed {
		logic bus_wake;
		logic timer_wake;
		logic hv_wake;
		logic gp_wake;
		logic overcurrent;
		logic open_load;
	} wgs_events_t;
	typedef struct packed {
		logic rd;
		logic clr;
		logic [6:0] addr;
		logic [7:0] clr_mask;
	} wgs_cmd_t;
endpackage : wgs_pkg

// ===== bench/wgs_host_model.sv
`timescale 1ns/1ps
module wgs_host_model (
	input wire logic CLK,
	input wire logic [7:0] RDATA,
	input wire logic RVALID,
	output wgs_pkg::wgs_cmd_t CMD
);
	import wgs_pkg::*;
	initial CMD = '0;
	////////////////////////////////////////////////////////////////////////
	// plain read
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
		int i;
		ok = 0;
		d = 8'h00;
		@(posedge CLK);
		CMD <= '{rd: 1'b1, clr: 1'b0, addr: a, clr_mask: 8'h00};
		@(posedge CLK);
		CMD.rd <= 1'b0;
		// bounded: answer is due one cycle after the request
		for (i = 0; i < 4 && !ok; i++) begin
			#1;
			if (RVALID === 1'b1) begin
				ok = 1;
				d = RDATA;
			end else begin
				@(posedge CLK);
			end
		end
	endtask : rd
	task automatic clr(input logic [6:0] a, input logic [7:0] m);
		@(posedge CLK);
		CMD <= '{rd: 1'b0, clr: 1'b1, addr: a, clr_mask: m};
		@(posedge CLK);
		CMD.clr <= 1'b0;
	endtask : clr
endmodule : wgs_host_model

// ===== bench/wgs_status_bank_test.sv
`timescale 1ns/1ps
module wgs_status_bank_test;
	import wgs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic restart = 1'b0;
	logic soft_rst = 1'b0;
	logic cyc = 1'b0;
	logic strobe = 1'b0;
	logic fs_exit = 1'b0;
	wgs_mode_t mode = M_NORMAL;
	logic trx = 1'b0;
	logic hv_func_en = 1'b0;
	logic hv_meas = 1'b0;
	logic test_pin = 1'b0;
	logic irq_pu = 1'b0;
	logic gp_pin = 1'b0;
	logic hv_pin = 1'b0;
	logic [7:0] rdata;
	logic rvalid;
	logic uv_en;
	wgs_gp_mode_t gp_mode = GP_OFF;
	wgs_events_t events = '0;
	wgs_cmd_t cmd;
	int num_errors = 0;
	int num_checks = 0;
	always #12.5 clk = ~clk;
	wgs_status_bank u_dut (.CLK(clk), .RST_N(rst_n), .SOFT_RESET(soft_rst), .RESTART(restart),
		.MODE(mode), .CYCLIC_SENSE(cyc), .SAMPLE_STROBE(strobe), .TRX_MODE_BIT(trx),
		.GP_MODE(gp_mode), .HV_FUNC_EN(hv_func_en), .HV_MEASURE_EN(hv_meas),
		.EVENTS(events), .FAILSAFE_EXIT(fs_exit), .TEST_PIN(test_pin), .IRQ_PULLUP(irq_pu),
		.GP_PIN(gp_pin), .HV_PIN(hv_pin), .CMD(cmd), .RDATA(rdata), .RVALID(rvalid),
		.SUPPLY_UV_CMP_EN(uv_en));
	wgs_host_model u_host (.CLK(clk), .RDATA(rdata), .RVALID(rvalid), .CMD(cmd));
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input string n, input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			num_errors++;
			$display("Error %s expected %h seen none", n, e);
			conclude();
		end else begin
			chk(n, e, d);
		end
	endtask : rchk
	task automatic ev(input wgs_events_t e);
		@(posedge clk);
		events <= e;
		@(posedge clk);
		events <= '0;
	endtask : ev
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rchk("wake_a", ADDR_WAKE_A, 8'h00);
		rchk("wake_b", ADDR_WAKE_B, 8'h00);
		rchk("oc", ADDR_OC, 8'h00);
		rchk("ol", ADDR_OL, 8'h00);
		rchk("unmapped", 7'h33, 8'h00);
		$display("test reset done");
		ev(6'h38);
		rchk("wake_a", ADDR_WAKE_A, 8'h31);
		u_host.clr(ADDR_WAKE_A, 8'h20);
		rchk("wake_a", ADDR_WAKE_A, 8'h11);
		u_host.clr(ADDR_OC, 8'hFF);
		repeat (20) @(posedge clk);
		rchk("wake_a", ADDR_WAKE_A, 8'h11);
		u_host.clr(ADDR_WAKE_A, 8'hFF);
		rchk("wake_a", ADDR_WAKE_A, 8'h00);
		$display("test wake_a done");
		ev(6'h04);
		rchk("wake_b", ADDR_WAKE_B, 8'h00);
		@(posedge clk);
		gp_mode <= GP_WAKE;
		ev(6'h04);
		rchk("wake_b", ADDR_WAKE_B, 8'h10);
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		rchk("wake_b", ADDR_WAKE_B, 8'h00);
		$display("test wake_b done");
		@(posedge clk);
		{test_pin, irq_pu, gp_pin, hv_pin, hv_func_en} <= 5'h1F;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hD1);
		rchk("level", ADDR_LEVEL, 8'hD1);
		@(posedge clk);
		hv_meas <= 1'b1;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hC0);
		@(posedge clk);
		{hv_meas, hv_pin} <= 2'h0;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hD0);
		$display("test level done");
		@(posedge clk);
		gp_mode <= GP_LOW_SW;
		ev(6'h03);
		rchk("oc", ADDR_OC, 8'h40);
		rchk("ol", ADDR_OL, 8'h00);
		@(posedge clk);
		gp_mode <= GP_HIGH_SW;
		ev(6'h01);
		@(posedge clk);
		gp_mode <= GP_OFF;
		rchk("oc", ADDR_OC, 8'h40);
		rchk("ol", ADDR_OL, 8'h40);
		u_host.clr(ADDR_OC, 8'h40);
		u_host.clr(ADDR_OL, 8'h40);
		rchk("oc", ADDR_OC, 8'h00);
		rchk("ol", ADDR_OL, 8'h00);
		$display("test switch done");
		@(posedge clk);
		gp_mode <= GP_FAIL_OUT;
		hv_func_en <= 1'b0;
		{gp_pin, hv_pin} <= 2'h1;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hD0);
		@(posedge clk);
		gp_mode <= GP_OFF;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hD0);
		@(posedge clk);
		gp_mode <= GP_WAKE;
		hv_func_en <= 1'b1;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hC1);
		$display("test freeze done");
		@(posedge clk);
		mode <= M_SLEEP;
		{gp_pin, hv_pin} <= 2'h2;
		repeat (5) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hC1);
		@(posedge clk);
		mode <= M_NORMAL;
		cyc <= 1'b1;
		repeat (3) @(posedge clk);
		rchk("level", ADDR_LEVEL, 8'hC1);
		@(posedge clk);
		strobe <= 1'b1;
		@(posedge clk);
		strobe <= 1'b0;
		rchk("level", ADDR_LEVEL, 8'hD0);
		@(posedge clk);
		cyc <= 1'b0;
		$display("test cyclic done");
		@(posedge clk);
		mode <= M_FAILSAFE;
		fs_exit <= 1'b1;
		events <= 6'h08;
		@(posedge clk);
		mode <= M_NORMAL;
		fs_exit <= 1'b0;
		events <= '0;
		rchk("wake_a", ADDR_WAKE_A, 8'h01);
		ev(6'h24);
		rchk("wake_a", ADDR_WAKE_A, 8'h21);
		rchk("wake_b", ADDR_WAKE_B, 8'h10);
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		rchk("wake_a", ADDR_WAKE_A, 8'h00);
		rchk("wake_b", ADDR_WAKE_B, 8'h00);
		$display("test soft reset done");
		@(posedge clk);
		trx <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("uv_en", 8'h01, {7'h00, uv_en});
		@(posedge clk);
		trx <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("uv_en", 8'h00, {7'h00, uv_en});
		$display("test supply done");
		conclude();
	end
endmodule : wgs_status_bank_test
